// >>> core/analog_die_spi_irq_wake.sv
// Functional notes
// - lin falling edge sets flag, interrupts if enabled
// - enabled lin falling edge in stop wakes system
// - enabled hall inputs raise hall interrupt
// - hall in stop sampled at watchdog checks
// - any over-current sets flag, may interrupt
// - exactly four wake-up sources
// - wake only when source mask set
// - frame is command plus data bytes
// - select low drives miso actively
// - miso on rise, mosi on fall
// - exactly sixteen sampling edges required
// - write commits at select rising edge
// - read data captured at parity bit
// - select high floats miso
// - command: address, rw, parity, unused
// - read ignores master data byte
// - write returns prior register value
// - parity checked on writes only
// - first byte is system status
// - reset clears all interrupt enables
// - write one clears flag
`include "spi_irq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module analog_die_spi_irq_wake (
  input wire logic clock,
  input wire logic rst,
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  input wire spi_irq_pkg::pins_t pins,
  output logic irq_o,
  output logic irq_oe,
  output logic mcu_wake,
  output logic main_regulator_on,
  output logic stop_mode,
  output spi_irq_pkg::ctrl_t ctrl
);
  // masked write helper for plain storage bits
  function automatic logic [7:0] wr_mask(input logic [7:0] d,
                                         input logic [7:0] m);
    wr_mask = d & m;
  endfunction : wr_mask
  // sticky flag: set beats clear
  function automatic logic sticky(input logic old, input logic clr,
                                  input logic set);
    sticky = set | (old & ~clr);
  endfunction : sticky

  // ---------------- link domain ----------------
  logic [7:0] fall_cnt; // free running sample edge count
  logic [15:0] shift; // mosi shift path
  logic [4:0] fpos; // sample position in frame
  logic [4:0] rpos; // launch position in frame
  logic [7:0] rd_hold; // data byte to return
  logic [7:0] snap [1:12]; // frozen register image
  logic [7:0] status_snap; // frozen status byte
  logic [4:0] link_addr; // address seen so far
  assign link_addr = shift[5:1];

  // free count and shift path on falling edges
  // sample on fall
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      fall_cnt <= 8'h00;
      shift <= 16'h0000;
    end else begin
      fall_cnt <= fall_cnt + 8'h01;
      shift <= {shift[14:0], mosi};
    end
  end

  // frame position, ended by select
  always_ff @(negedge sclk or posedge ss_n) begin
    if (ss_n) begin
      fpos <= 5'h00;
    end else if (fpos != 5'h1f) begin
      fpos <= fpos + 5'h01;
    end
  end

  // read data latched as parity bit arrives
  // capture at parity
  always_ff @(negedge sclk or posedge ss_n) begin
    if (ss_n) begin
      rd_hold <= `RESET_BYTE;
    end else if (fpos == `PARITY_EDGE) begin
      if (link_addr >= `ADDR_HALF_BRIDGE_OUTPUT_REG && link_addr <= `ADDR_LAST_REG) begin
        rd_hold <= snap[link_addr];
      end else begin
        rd_hold <= `RESET_BYTE;
      end
    end
  end

  // miso launch on rising edges, status first
  // launch on rise
  always_ff @(posedge sclk or posedge ss_n) begin
    if (ss_n) begin
      rpos <= 5'h00;
      miso_o <= 1'b0;
    end else begin
      if (rpos != 5'h1f) begin
        rpos <= rpos + 5'h01;
      end
      if (rpos < 5'h08) begin
        miso_o <= status_snap[~rpos[2:0]];
      end else if (rpos < 5'h10) begin
        miso_o <= rd_hold[~rpos[2:0]];
      end else begin
        miso_o <= 1'b0;
      end
    end
  end

  // miso enable follows select edges
  // drive on select fall
  always_ff @(negedge ss_n or posedge ss_n) begin
    if (ss_n) begin
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= 1'b1;
    end
  end

  // ---------------- core domain ----------------
  logic [2:0] ss_sync; // select synchroniser plus history
  spi_irq_pkg::pins_t pin_s1; // first stage
  spi_irq_pkg::pins_t pin_s2; // second stage
  spi_irq_pkg::pins_t pin_d; // history for edges
  logic [7:0] cnt_base; // sample count at last frame end
  logic frame_end; // select rose, frame quiet
  spi_irq_pkg::frame_t frame; // received frame
  logic frame_ok; // exactly sixteen edges
  logic wr_ok; // write accepted
  logic [7:0] hb_out, hb_ctl, sys_ctl, irq_en, rst_en, mux_sel;
  logic [7:0] hall_ctl, wd_ctl, power_output_control_ctl;
  logic hall_f, lin_f, temp_f, lowv_f, highv_f; // interrupt flags
  logic hb_ocf, hs_ocf, switched_sensor_supply_ocf; // over-current sources
  logic ovc_f; // combined over-current flag
  logic [7:0] flags_rd; // interrupt flag byte
  logic [7:0] status_rd; // system status byte
  spi_irq_pkg::pwr_state_t state; // run or stop
  logic lin_fall, hall_run_evt, hall_stop_evt, check_rise;
  logic wake_rise, lvr_rise, wake_evt;
  logic wr_flags, wr_stat; // write strobes to w1c bytes

  // two-flop synchronisers for select and pins
  always_ff @(posedge clock) begin
    if (rst) begin
      ss_sync <= 3'h7;
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d <= '0;
    end else begin
      ss_sync <= {ss_sync[1:0], ss_n};
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // frame end and validation
  assign frame_end = ss_sync[1] & ~ss_sync[2];
  assign frame = shift;
  assign frame_ok = (fall_cnt - cnt_base) == `FRAME_EDGES;
  assign wr_ok = frame_end & frame_ok & ~frame.rw &
    (frame.parity == ^{frame.rw, frame.register_address_field});
  assign wr_flags = wr_ok &
    (frame.register_address_field == `ADDR_IRQ_FLAG);
  assign wr_stat = wr_ok &
    (frame.register_address_field == `ADDR_SYS_STAT);

  // sample count baseline per frame
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_base <= 8'h00;
    end else if (frame_end) begin
      cnt_base <= fall_cnt;
    end
  end

  // plain control registers, commit at select rise
  // commit on select rise
  always_ff @(posedge clock) begin
    if (rst) begin
      hb_out <= `RESET_BYTE;
      hb_ctl <= `RESET_BYTE;
      sys_ctl <= `RESET_BYTE;
      rst_en <= `RESET_BYTE;
      mux_sel <= `RESET_BYTE;
      hall_ctl <= `RESET_BYTE;
      wd_ctl <= `RESET_BYTE;
      power_output_control_ctl <= `RESET_BYTE;
    end else if (wr_ok) begin
      unique case (frame.register_address_field)
        `ADDR_HB_OUT: hb_out <= frame.data;
        `ADDR_HB_CTL: hb_ctl <= wr_mask(frame.data, `MASK_HB_CTL);
        `ADDR_SYS_CTL: sys_ctl <= wr_mask(frame.data, `MASK_SYS_CTL);
        `ADDR_RST_EN: rst_en <= wr_mask(frame.data, `MASK_RST_EN);
        `ADDR_MUX_SEL: mux_sel <= wr_mask(frame.data, `MASK_MUX_SEL);
        `ADDR_HALL_CTL: hall_ctl <= wr_mask(frame.data, `MASK_HALL_CTL);
        `ADDR_WD_CTL: wd_ctl <= wr_mask(frame.data, `MASK_WD_CTL);
        `ADDR_POWER_OUTPUT_CONTROL_CTL: power_output_control_ctl <= wr_mask(frame.data, `MASK_POWER_OUTPUT_CONTROL_CTL);
        default: ; // flags, status, read-only and unmapped
      endcase
    end
  end

  // interrupt enables
  // enables cleared
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_en <= `RESET_BYTE;
    end else if (wr_ok &&
                 frame.register_address_field == `ADDR_IRQ_EN) begin
      irq_en <= wr_mask(frame.data, `MASK_IRQ_EN);
    end
  end

  // event detection on synchronised pins
  assign lin_fall = pin_d.lin_rx & ~pin_s2.lin_rx;
  assign check_rise = pin_s2.wd_check & ~pin_d.wd_check;
  assign wake_rise = pin_s2.wd_wake & ~pin_d.wd_wake;
  assign lvr_rise = pin_s2.low_voltage_reset & ~pin_d.low_voltage_reset;
  assign hall_run_evt = (state == spi_irq_pkg::RUN) &
    (|((pin_s2.hall_inputs ^ pin_d.hall_inputs) & hall_ctl[2:0]));
  assign hall_stop_evt = (state == spi_irq_pkg::STOP) & check_rise &
    (|(pin_s2.hall_inputs & hall_ctl[2:0]));

  // interrupt flags, set wins over clear
  // lin edge flag
  always_ff @(posedge clock) begin
    if (rst) begin
      hall_f <= 1'b0;
      lin_f <= 1'b0;
      temp_f <= 1'b0;
      lowv_f <= 1'b0;
      highv_f <= 1'b0;
    end else begin
      hall_f <= sticky(hall_f, wr_flags & frame.data[`BIT_HALL],
                       hall_run_evt | hall_stop_evt);
      lin_f <= sticky(lin_f, wr_flags & frame.data[`BIT_LIN], lin_fall);
      temp_f <= sticky(temp_f, wr_flags & frame.data[`BIT_TEMP],
                       pin_s2.high_temp);
      lowv_f <= sticky(lowv_f, wr_flags & frame.data[`BIT_LOWV],
                       pin_s2.low_volt);
      highv_f <= sticky(highv_f, wr_flags & frame.data[`BIT_HIGHV],
                        pin_s2.high_volt);
    end
  end

  // over-current sources, cleared through status byte
  // over-current flags
  always_ff @(posedge clock) begin
    if (rst) begin
      hb_ocf <= 1'b0;
      hs_ocf <= 1'b0;
      switched_sensor_supply_ocf <= 1'b0;
    end else begin
      hb_ocf <= sticky(hb_ocf, wr_stat & frame.data[`BIT_ST_HB],
                       pin_s2.hb_oc);
      hs_ocf <= sticky(hs_ocf, wr_stat & frame.data[`BIT_ST_HS],
                       pin_s2.hs_oc);
      switched_sensor_supply_ocf <= sticky(switched_sensor_supply_ocf, wr_stat & frame.data[`BIT_ST_SWITCHED_SENSOR_SUPPLY],
                         pin_s2.switched_sensor_supply_oc);
    end
  end
  assign ovc_f = hb_ocf | hs_ocf | switched_sensor_supply_ocf;

  // readable flag and status bytes
  assign flags_rd = {1'b0, hall_f, lin_f, temp_f, lowv_f, highv_f,
                     ovc_f, 1'b0};
  assign status_rd = {2'b00, switched_sensor_supply_ocf, hs_ocf, lowv_f, highv_f,
                      hb_ocf, temp_f};

  // wake-up decision, each source under its mask
  // four wake sources
  assign wake_evt = (state == spi_irq_pkg::STOP) &
    ((lin_fall & irq_en[`BIT_LIN]) |
     (wake_rise & wd_ctl[`BIT_WD_IRQ_EN]) |
     (hall_stop_evt & irq_en[`BIT_HALL]) |
     (lvr_rise & irq_en[`BIT_LOWV]));

  // power state: stop on request, run on wake
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= spi_irq_pkg::RUN;
    end else begin
      unique case (state)
        spi_irq_pkg::RUN: begin
          if (wr_ok && frame.data[`BIT_GO_STOP] &&
              frame.register_address_field == `ADDR_SYS_CTL) begin
            state <= spi_irq_pkg::STOP;
          end
        end
        spi_irq_pkg::STOP: begin
          if (wake_evt) begin
            state <= spi_irq_pkg::RUN;
          end
        end
      endcase
    end
  end

  // wake pulse and regulator outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      mcu_wake <= 1'b0;
      main_regulator_on <= 1'b1;
      stop_mode <= 1'b0;
    end else begin
      mcu_wake <= wake_evt;
      main_regulator_on <= (state == spi_irq_pkg::RUN) | wake_evt;
      stop_mode <= (state == spi_irq_pkg::STOP) & ~wake_evt;
    end
  end

  // open-drain interrupt line
  // flag and enable pair
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_o <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      irq_o <= 1'b0;
      irq_oe <= |(flags_rd & irq_en);
    end
  end

  // register image for the link, frozen while selected
  always_ff @(posedge clock) begin
    if (rst) begin
      status_snap <= `RESET_BYTE;
      for (int i = 1; i <= 12; i++) begin
        snap[i] <= `RESET_BYTE;
      end
    end else if (ss_sync[1]) begin
      status_snap <= status_rd;
      snap[1] <= hb_out;
      snap[2] <= hb_ctl;
      snap[3] <= sys_ctl;
      snap[4] <= irq_en;
      snap[5] <= flags_rd;
      snap[6] <= rst_en;
      snap[7] <= mux_sel;
      snap[8] <= hall_ctl;
      snap[9] <= {5'h00, pin_s2.hall_inputs};
      snap[10] <= wd_ctl;
      snap[11] <= power_output_control_ctl;
      snap[12] <= status_rd;
    end
  end

  // control outputs come straight from storage
  assign ctrl = '{half_bridge_output: hb_out,
                  half_bridge_control: hb_ctl,
                  reset_enable_mask: rst_en,
                  analog_mux_select: mux_sel,
                  watchdog_control: wd_ctl,
                  power_output_control: power_output_control_ctl};

  // ---------------- checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // reset leaves enables clear
  en_reset_a: assert property ($past(rst) |-> irq_en == 8'h00)
    else $error("enables not clear after reset");
  // lin edge seen as flag
  lin_flag_a: assert property (lin_fall |=> lin_f)
    else $error("lin edge lost");
  // zero write leaves flag alone
  w1c_hold_a: assert property (
    lin_f && !(wr_flags && frame.data[`BIT_LIN]) |=> lin_f)
    else $error("lin flag cleared without one");
  // enabled lin edge wakes from stop
  lin_wake_a: assert property (
    state == spi_irq_pkg::STOP && lin_fall && irq_en[`BIT_LIN]
    |=> mcu_wake && state == spi_irq_pkg::RUN ##1 !mcu_wake)
    else $error("lin wake missing");
  // no wake without any source
  masked_wake_a: assert property (
    !wake_evt |=> !mcu_wake)
    else $error("wake without masked source");
  // hall flag only at watchdog checks in stop
  hall_stop_a: assert property (
    state == spi_irq_pkg::STOP && !check_rise && !hall_f |=> !hall_f)
    else $error("hall sampled outside check");
  // over-current sets flag
  ovc_set_a: assert property (
    pin_s2.hb_oc || pin_s2.hs_oc || pin_s2.switched_sensor_supply_oc |=> ovc_f)
    else $error("over-current flag missing");
  // bad or read frames keep registers
  bad_frame_a: assert property (
    frame_end && !wr_ok |=> $stable(irq_en) && $stable(hb_out))
    else $error("register changed by rejected frame");
  // irq follows flag and enable
  irq_pair_a: assert property (
    |(flags_rd & irq_en) |=> irq_oe ##0 !irq_o)
    else $error("irq not asserted");
  // irq released when no pair remains
  irq_free_a: assert property (
    !(|(flags_rd & irq_en)) |=> !irq_oe)
    else $error("irq not released");

  // main scenarios
  write_cv: cover property (wr_ok);
  read_cv: cover property (frame_end && frame_ok && frame.rw);
  wake_cv: cover property (state == spi_irq_pkg::STOP ##1 mcu_wake);
  bad_par_cv: cover property (frame_end && frame_ok && !frame.rw && !wr_ok);
endmodule : analog_die_spi_irq_wake
`default_nettype wire

// >>> core/spi_irq_params.svh
`ifndef SPI_IRQ_PARAMS_SVH
`define SPI_IRQ_PARAMS_SVH
// register addresses
`define ADDR_HALF_BRIDGE_OUTPUT_REG 5'h01
`define ADDR_LAST_REG 5'h0c
`define ADDR_HB_OUT 5'h01
`define ADDR_HB_CTL 5'h02
`define ADDR_SYS_CTL 5'h03
`define ADDR_IRQ_EN 5'h04
`define ADDR_IRQ_FLAG 5'h05
`define ADDR_RST_EN 5'h06
`define ADDR_MUX_SEL 5'h07
`define ADDR_HALL_CTL 5'h08
`define ADDR_HALL_STAT 5'h09
`define ADDR_WD_CTL 5'h0a
`define ADDR_POWER_OUTPUT_CONTROL_CTL 5'h0b
`define ADDR_SYS_STAT 5'h0c
// writable bit masks
`define MASK_HB_CTL 8'hc7
`define MASK_SYS_CTL 8'he0
`define MASK_IRQ_EN 8'h7e
`define MASK_RST_EN 8'h83
`define MASK_MUX_SEL 8'h0f
`define MASK_HALL_CTL 8'h07
`define MASK_WD_CTL 8'h3f
`define MASK_POWER_OUTPUT_CONTROL_CTL 8'h3f
// interrupt enable / flag bit positions
`define BIT_HALL 6
`define BIT_LIN 5
`define BIT_TEMP 4
`define BIT_LOWV 3
`define BIT_HIGHV 2
`define BIT_OVC 1
// watchdog control bit positions
`define BIT_WD_IRQ_EN 3
// go-to-stop bit in system control
`define BIT_GO_STOP 0
// over-current bits in system status
`define BIT_ST_SWITCHED_SENSOR_SUPPLY 5
`define BIT_ST_HS 4
`define BIT_ST_HB 1
// frame length in sampling edges
`define FRAME_EDGES 8'h10
// parity sampling edge index (0 based)
`define PARITY_EDGE 5'h06
`define RESET_BYTE 8'h00
`endif

// >>> core/spi_irq_pkg.sv
package spi_irq_pkg;
  // power state of the die
  typedef enum logic {RUN = 1'b0, STOP = 1'b1} pwr_state_t;
  // asynchronous pins entering the core clock domain
  typedef struct packed {
    logic lin_rx;
    logic [2:0] hall_inputs;
    logic hb_oc;
    logic hs_oc;
    logic switched_sensor_supply_oc;
    logic high_temp;
    logic low_volt;
    logic high_volt;
    logic wd_check;
    logic wd_wake;
    logic low_voltage_reset;
  } pins_t;
  // captured serial frame, first bit in msb
  typedef struct packed {
    logic [4:0] register_address_field;
    logic rw;
    logic parity;
    logic unused;
    logic [7:0] data;
  } frame_t;
  // control bytes driven out to the analog blocks
  typedef struct packed {
    logic [7:0] half_bridge_output;
    logic [7:0] half_bridge_control;
    logic [7:0] reset_enable_mask;
    logic [7:0] analog_mux_select;
    logic [7:0] watchdog_control;
    logic [7:0] power_output_control;
  } ctrl_t;
endpackage : spi_irq_pkg

// >>> sim/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic ss_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // data wire as the host sees it, floating when not driven
  wire miso_line;
  assign miso_line = miso_oe ? miso_o : 1'bz;

  // idle levels, clock stands still outside frames
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // command byte builder
  // address, rw, parity, spare
  function automatic logic [7:0] cmd(input logic [4:0] a, input logic rw,
      input logic bad);
    cmd = {a, rw, (^{rw, a}) ^ bad, 1'b0};
  endfunction : cmd

  // one frame with a chosen count of sampling edges
  // two bytes, one fall per bit
  task automatic frame(input logic [15:0] tx, input int edges,
      output logic [15:0] rx, output logic oe_seen);
    int i;
    rx = 16'h0000;
    ss_n = 1'b0;
    #150;
    oe_seen = miso_oe;
    for (i = 0; i < edges; i++) begin
      // data changes on rise, held across fall
      sclk = 1'b1;
      mosi = (i < 16) ? tx[15 - i] : 1'b0;
      #15;
      if (i < 16) rx[15 - i] = miso_line;
      sclk = 1'b0;
      #15;
    end
    #15;
    ss_n = 1'b1;
    // released data line shows the inverse level
    mosi = ~mosi;
    #240;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// >>> sim/analog_die_spi_irq_wake_bench.sv
`include "spi_irq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module analog_die_spi_irq_wake_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  wire ss_n, sclk, mosi;
  logic miso_o, miso_oe, irq_o, irq_oe, mcu_wake;
  logic main_regulator_on, stop_mode;
  spi_irq_pkg::pins_t pins;
  spi_irq_pkg::ctrl_t ctrl;
  int fails = 0;
  int checked = 0;
  int i;
  // writable registers and their masks
  logic [4:0] adr [6] = '{5'h01, 5'h02, 5'h06, 5'h07, 5'h08, 5'h0b};
  logic [7:0] msk [6] = '{8'hff, 8'hc7, 8'h83, 8'h0f, 8'h07, 8'h3f};
  // over-current status bits: half-bridge, high side, sensor supply
  logic [7:0] ocs [3] = '{8'h02, 8'h10, 8'h20};

  // core clock, 40 ns
  always #20 clock = ~clock;

  analog_die_spi_irq_wake u_analog_die_spi_irq_wake (
    .clock(clock), .rst(rst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .pins(pins), .irq_o(irq_o),
    .irq_oe(irq_oe), .mcu_wake(mcu_wake),
    .main_regulator_on(main_regulator_on), .stop_mode(stop_mode),
    .ctrl(ctrl)
  );

  spi_host_model u_spi_host_model (
    .ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe)
  );

  // compare one byte
  task automatic check8(input string name, input logic [7:0] exp,
      input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : check8

  // compare one bit
  task automatic check1(input string name, input logic exp,
      input logic got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %b seen %b", name, exp, got);
      fails++;
    end
  endtask : check1

  // one serial access, returns status and data bytes
  task automatic xfer(input logic [4:0] a, input logic rw,
      input logic [7:0] d, input logic bad, input int n,
      output logic [7:0] st, output logic [7:0] rv);
    logic [15:0] rx;
    logic oe;
    u_spi_host_model.frame({u_spi_host_model.cmd(a, rw, bad), d}, n, rx,
      oe);
    check1("miso_oe in frame", 1'b1, oe);
    check1("miso_oe idle", 1'b0, miso_oe);
    {st, rv} = rx;
  endtask : xfer

  // read with expected status and data
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] est,
      input logic [7:0] ed);
    logic [7:0] st, rv;
    xfer(a, 1'b1, 8'hc3, 1'b0, 16, st, rv);
    check8("status byte", est, st);
    check8("read data", ed, rv);
  endtask : rd_chk

  // write, checking the prior value returned
  task automatic wr_chk(input logic [4:0] a, input logic [7:0] d,
      input logic [7:0] prior);
    logic [7:0] st, rv;
    xfer(a, 1'b0, d, 1'b0, 16, st, rv);
    check8("prior data", prior, rv);
  endtask : wr_chk

  // bounded wait for the wake pulse
  task automatic wait_wake;
    int n;
    n = 0;
    while (mcu_wake !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    check1("mcu_wake", 1'b1, mcu_wake);
    @(negedge clock);
    check1("stop_mode after wake", 1'b0, stop_mode);
  endtask : wait_wake

  // pin change then settle through the sync chain
  task automatic settle;
    repeat (8) @(negedge clock);
  endtask : settle

  // verdict and end of run
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // watchdog against a hang
  initial begin
    #400000;
    fails++;
    give_verdict();
  end

  // main sequence
  initial begin
    logic [7:0] st, rv;
    pins = '0;
    pins.lin_rx = 1'b1;
    repeat (16) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    repeat (4) @(negedge clock);
    check1("irq_oe reset", 1'b0, irq_oe);
    check1("irq_o reset", 1'b0, irq_o);
    check1("regulator reset", 1'b1, main_regulator_on);
    rd_chk(`ADDR_IRQ_EN, 8'h00, 8'h00);
    wr_chk(`ADDR_IRQ_EN, 8'h7e, 8'h00);
    wr_chk(`ADDR_IRQ_EN, 8'h00, 8'h7e);
    // write all ones, read back the writable bits
    for (i = 0; i < 6; i++) begin
      wr_chk(adr[i], 8'hff, 8'h00);
      rd_chk(adr[i], 8'h00, msk[i]);
    end
    check8("ctrl hb out", 8'hff, ctrl.half_bridge_output);
    check8("ctrl power_output_control", 8'h3f, ctrl.power_output_control);
    check8("ctrl hb ctl", 8'hc7, ctrl.half_bridge_control);
    check8("ctrl rst en", 8'h83, ctrl.reset_enable_mask);
    check8("ctrl mux", 8'h0f, ctrl.analog_mux_select);
    rd_chk(5'h1f, 8'h00, 8'h00);
    // bad parity and wrong edge counts change nothing
    xfer(`ADDR_HB_OUT, 1'b0, 8'h00, 1'b1, 16, st, rv);
    xfer(`ADDR_HB_OUT, 1'b0, 8'h00, 1'b0, 15, st, rv);
    xfer(`ADDR_HB_OUT, 1'b0, 8'h00, 1'b0, 17, st, rv);
    xfer(`ADDR_HB_OUT, 1'b1, 8'h00, 1'b1, 16, st, rv);
    check8("read bad parity", 8'hff, rv);
    rd_chk(`ADDR_HB_OUT, 8'h00, 8'hff);
    // lin falling edge, flag, enable, clear
    @(negedge clock) pins.lin_rx = 1'b0;
    settle();
    rd_chk(`ADDR_IRQ_FLAG, 8'h00, 8'h20);
    check1("irq_oe masked", 1'b0, irq_oe);
    wr_chk(`ADDR_IRQ_EN, 8'h20, 8'h00);
    check1("irq_oe lin", 1'b1, irq_oe);
    wr_chk(`ADDR_IRQ_FLAG, 8'h00, 8'h20);
    check1("irq_oe kept", 1'b1, irq_oe);
    wr_chk(`ADDR_IRQ_FLAG, 8'h20, 8'h20);
    check1("irq_oe cleared", 1'b0, irq_oe);
    pins.lin_rx = 1'b1;
    // each over-current source
    wr_chk(`ADDR_IRQ_EN, 8'h02, 8'h20);
    for (i = 0; i < 3; i++) begin
      {pins.hb_oc, pins.hs_oc, pins.switched_sensor_supply_oc} = 3'b100 >> i;
      settle();
      {pins.hb_oc, pins.hs_oc, pins.switched_sensor_supply_oc} = 3'b000;
      settle();
      rd_chk(`ADDR_IRQ_FLAG, ocs[i], 8'h02);
      check1("irq_oe oc", 1'b1, irq_oe);
      wr_chk(`ADDR_SYS_STAT, ocs[i], ocs[i]);
      check1("irq_oe oc off", 1'b0, irq_oe);
    end
    // hall change on an enabled pin only
    wr_chk(`ADDR_HALL_CTL, 8'h01, 8'h07);
    wr_chk(`ADDR_IRQ_EN, 8'h40, 8'h02);
    @(negedge clock) pins.hall_inputs = 3'b010;
    settle();
    rd_chk(`ADDR_IRQ_FLAG, 8'h00, 8'h00);
    pins.hall_inputs = 3'b011;
    settle();
    rd_chk(`ADDR_HALL_STAT, 8'h00, 8'h03);
    rd_chk(`ADDR_IRQ_FLAG, 8'h00, 8'h40);
    check1("irq_oe hall", 1'b1, irq_oe);
    pins.hall_inputs = 3'b000;
    settle();
    wr_chk(`ADDR_IRQ_FLAG, 8'h40, 8'h40);
    // stop, masked lin edge must not wake, watchdog wake does
    wr_chk(`ADDR_IRQ_EN, 8'h00, 8'h40);
    wr_chk(`ADDR_WD_CTL, 8'h08, 8'h00);
    check8("ctrl wd", 8'h08, ctrl.watchdog_control);
    wr_chk(`ADDR_SYS_CTL, 8'h01, 8'h00);
    check1("stop_mode", 1'b1, stop_mode);
    check1("regulator off", 1'b0, main_regulator_on);
    @(negedge clock) pins.lin_rx = 1'b0;
    repeat (20) @(negedge clock);
    check1("stop held", 1'b1, stop_mode);
    pins.lin_rx = 1'b1;
    pins.wd_wake = 1'b1;
    wait_wake();
    check1("regulator on", 1'b1, main_regulator_on);
    pins.wd_wake = 1'b0;
    // hall wake only at a watchdog check
    wr_chk(`ADDR_IRQ_EN, 8'h40, 8'h00);
    wr_chk(`ADDR_SYS_CTL, 8'h01, 8'h00);
    @(negedge clock) pins.hall_inputs = 3'b001;
    repeat (20) @(negedge clock);
    check1("hall no check", 1'b1, stop_mode);
    pins.wd_check = 1'b1;
    wait_wake();
    pins.wd_check = 1'b0;
    pins.hall_inputs = 3'b000;
    // lin edge wake with its mask set
    wr_chk(`ADDR_IRQ_EN, 8'h20, 8'h40);
    wr_chk(`ADDR_SYS_CTL, 8'h01, 8'h00);
    @(negedge clock) pins.lin_rx = 1'b0;
    wait_wake();
    // low voltage reset wake with its mask set
    wr_chk(`ADDR_IRQ_EN, 8'h08, 8'h20);
    wr_chk(`ADDR_SYS_CTL, 8'h01, 8'h00);
    check1("stop before lvr", 1'b1, stop_mode);
    @(negedge clock) pins.low_voltage_reset = 1'b1;
    wait_wake();
    check1("irq_o idle", 1'b0, irq_o);
    give_verdict();
  end
endmodule : analog_die_spi_irq_wake_bench
`default_nettype wire
